// ---- design/scl_defines.svh ----
// Register map, field positions and fixed figures of the calibration loader
// Overview of operation
// - Command bits 0-2 drive clock, data, select
// - Readback bit 0 shows store data-out level
// - Store holds 512 locations of 8 bits
// - Store ignores all traffic while select low
// - Converters change only on load strobe pulse
// - Command bits 3-5 are three load strobes
// - Lowest 256 store bytes are reserved
// - Top 128 factory, next 128 user constants
// - Five user sets start at location 371
// - Header: board, revision, date at 511-506
// - 8-bit variant constants at 433-437
// - Eight-bit device holds twelve 8-bit converters
// - 12-bit variant reference and converter 8 places
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

// Register port addresses
`define SCL_ADDR_COMMAND 4'h0
`define SCL_ADDR_READBACK 4'h1

// Command register field positions
`define SCL_BIT_SCLK 0
`define SCL_BIT_SDI 1
`define SCL_BIT_CS 2
`define SCL_BIT_LD0 3
`define SCL_BIT_LD1 4
`define SCL_BIT_LD2 5
`define SCL_COMMAND_RESET 8'h00

// Readback register field positions
`define SCL_BIT_DOUT 0
`define SCL_BIT_WEL 1
`define SCL_BIT_BUSY 2
`define SCL_BIT_REFUSED 3

// Serial store frame: 7-bit op, 9-bit address, 8-bit data
`define SCL_HDR_LAST 4'hf
`define SCL_BYTE_LAST 3'h7
`define SCL_OP_READ 7'h03
`define SCL_OP_WRITE 7'h02
`define SCL_OP_WREN 7'h06
`define SCL_OP_WRDI 7'h04

// Store map: 512 x 8
`define SCL_STORE_DEPTH 512
`define SCL_RESERVED_LAST 9'h0ff
`define SCL_USER_BASE 9'h100
`define SCL_USER_LAST 9'h17f
`define SCL_FACTORY_BASE 9'h180
`define SCL_USER_SETS_BASE 9'h173
`define SCL_LOC_BOARD 9'h1ff
`define SCL_LOC_REVISION 9'h1fe
`define SCL_LOC_SUBREVISION 9'h1fd
`define SCL_LOC_YEAR 9'h1fc
`define SCL_LOC_MONTH 9'h1fb
`define SCL_LOC_DAY 9'h1fa
`define SCL_LOC_V8_REF_LSB 9'h1b5
`define SCL_LOC_V8_CONST_LOW 9'h1b1
`define SCL_LOC_V12_REF_MSB 9'h1bf
`define SCL_LOC_V12_REF_LSB 9'h1be
`define SCL_LOC_V12_BIPOLAR_MSB 9'h1bd
`define SCL_LOC_V12_UNIPOLAR_MSB 9'h1b8

// Trim converters
`define SCL_TRIM_CHANNELS 12
`define SCL_TRIM_LAST_CHANNEL 4'hb

`endif

// ---- design/scl_loader.sv ----
// Calibration loader: command/readback registers, serial store and trim converters
//
// Our own choices: the address-and-strobe port and the address map.
`include "scl_defines.svh"
module scl_loader (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic serial_clock_o,
    output logic serial_data_o,
    output logic nvm_chip_select_o,
    output logic [8*`SCL_TRIM_CHANNELS-1:0] trim_bank0_o,
    output logic [8*`SCL_TRIM_CHANNELS-1:0] trim_bank1_o,
    output logic [11:0] trim_wide_o
);

    scl_pkg::scl_command_type command;
    scl_pkg::scl_command_type command_prev;
    scl_pkg::scl_state_type state;

    logic sclk_rise;
    logic sclk_fall;
    logic ld0_rise;
    logic ld1_rise;
    logic ld2_rise;

    logic [15:0] hdr_shift;
    logic [15:0] next_hdr;
    logic [3:0] hdr_count;
    logic [8:0] cur_addr;
    logic [6:0] next_op;
    logic [8:0] next_addr;

    logic [7:0] out_shift;
    logic [2:0] out_count;
    logic nvm_data_out_bit;

    logic [7:0] in_shift;
    logic [7:0] next_in;
    logic [2:0] in_count;
    logic write_enable_latch;
    logic write_refused;
    logic addr_writable;

    logic mem_rd_en;
    logic mem_wr_en;
    logic [8:0] mem_addr;
    logic [7:0] mem_rdata;

    logic [11:0] trim_shift;

    // Command register; write-only, so software cannot read it back
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            command <= `SCL_COMMAND_RESET;
        end
        else if (wr_i && addr_i == `SCL_ADDR_COMMAND)
        begin
            command <= wdata_i;
        end
    end

    // Previous command, for edge finding on the clock and strobe lines
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            command_prev <= `SCL_COMMAND_RESET;
        end
        else
        begin
            command_prev <= command;
        end
    end

    // Edges of the software-toggled lines; one register write per edge
    assign sclk_rise = command.sclk & ~command_prev.sclk;
    assign sclk_fall = ~command.sclk & command_prev.sclk;
    assign ld0_rise = command.ld0 & ~command_prev.ld0;
    assign ld1_rise = command.ld1 & ~command_prev.ld1;
    assign ld2_rise = command.ld2 & ~command_prev.ld2;

    // Shared lines leave the block straight from the command register
    assign serial_clock_o = command.sclk;
    assign serial_data_o = command.sdi;
    assign nvm_chip_select_o = command.cs;

    // Header bits as they will stand after this clock rise, MSB first
    assign next_hdr = {hdr_shift[14:0], command.sdi};
    assign next_op = next_hdr[15:9];
    assign next_addr = next_hdr[8:0];
    assign next_in = {in_shift[6:0], command.sdi};

    // Only the user constants region may be written; reserved and factory stay intact
    assign addr_writable = (cur_addr >= `SCL_USER_BASE)
                           && (cur_addr <= `SCL_USER_LAST);

    // Store engine phase; deselect returns it to header collection
    always_ff @(posedge clock_i)
    begin
        if (reset_i || !command.cs)
        begin
            state <= scl_pkg::SCL_HEADER;
        end
        else if (sclk_rise)
        begin
            unique case (state)
                scl_pkg::SCL_HEADER:
                begin
                    if (hdr_count == `SCL_HDR_LAST)
                    begin
                        if (next_op == `SCL_OP_READ)
                        begin
                            state <= scl_pkg::SCL_READ_OUT;
                        end
                        else if (next_op == `SCL_OP_WRITE && write_enable_latch)
                        begin
                            state <= scl_pkg::SCL_WRITE_IN;
                        end
                        else
                        begin
                            state <= scl_pkg::SCL_IGNORE;
                        end
                    end
                end
                scl_pkg::SCL_WRITE_IN:
                begin
                    if (in_count == `SCL_BYTE_LAST)
                    begin
                        state <= scl_pkg::SCL_IGNORE; // One byte per selection
                    end
                end
                scl_pkg::SCL_READ_OUT:
                begin
                    state <= scl_pkg::SCL_READ_OUT;
                end
                scl_pkg::SCL_IGNORE:
                begin
                    state <= scl_pkg::SCL_IGNORE;
                end
            endcase
        end
    end

    // Header shift register and bit count, live only while selected
    always_ff @(posedge clock_i)
    begin
        if (reset_i || !command.cs)
        begin
            hdr_shift <= 16'h0000;
            hdr_count <= 4'h0;
        end
        else if (sclk_rise && state == scl_pkg::SCL_HEADER)
        begin
            hdr_shift <= next_hdr;
            hdr_count <= hdr_count + 4'h1;
        end
    end

    // Current store address: taken from the header, stepped after each byte out
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            cur_addr <= 9'h000;
        end
        else if (command.cs && sclk_rise && state == scl_pkg::SCL_HEADER
                 && hdr_count == `SCL_HDR_LAST)
        begin
            cur_addr <= next_addr;
        end
        else if (command.cs && sclk_fall && state == scl_pkg::SCL_READ_OUT
                 && out_count == `SCL_BYTE_LAST)
        begin
            cur_addr <= cur_addr + 9'h001; // Sequential read wraps at 511
        end
    end

    // Array port: fetch on header end and after each byte, so data wait ready
    always_comb
    begin
        mem_rd_en = 1'b0;
        mem_addr = cur_addr;
        if (command.cs && sclk_rise && state == scl_pkg::SCL_HEADER
            && hdr_count == `SCL_HDR_LAST && next_op == `SCL_OP_READ)
        begin
            mem_rd_en = 1'b1;
            mem_addr = next_addr;
        end
        else if (command.cs && sclk_fall && state == scl_pkg::SCL_READ_OUT
                 && out_count == `SCL_BYTE_LAST)
        begin
            mem_rd_en = 1'b1;
            mem_addr = cur_addr + 9'h001;
        end
    end

    // Array write only at the last data bit of an enabled, selected write
    assign mem_wr_en = command.cs && sclk_rise && state == scl_pkg::SCL_WRITE_IN
                       && in_count == `SCL_BYTE_LAST && addr_writable;

    // Data out: bits leave MSB first on each falling clock edge
    always_ff @(posedge clock_i)
    begin
        if (reset_i || !command.cs)
        begin
            out_shift <= 8'h00;
            out_count <= 3'h0;
            nvm_data_out_bit <= 1'b0; // Line idles low when deselected
        end
        else if (sclk_fall && state == scl_pkg::SCL_READ_OUT)
        begin
            if (out_count == 3'h0)
            begin
                nvm_data_out_bit <= mem_rdata[7];
                out_shift <= {mem_rdata[6:0], 1'b0};
            end
            else
            begin
                nvm_data_out_bit <= out_shift[7];
                out_shift <= {out_shift[6:0], 1'b0};
            end
            out_count <= out_count + 3'h1;
        end
    end

    // Write data collection, eight bits after the header
    always_ff @(posedge clock_i)
    begin
        if (reset_i || !command.cs)
        begin
            in_shift <= 8'h00;
            in_count <= 3'h0;
        end
        else if (sclk_rise && state == scl_pkg::SCL_WRITE_IN)
        begin
            in_shift <= next_in;
            in_count <= in_count + 3'h1;
        end
    end

    // Write enable latch: set and cleared by commands, spent by a write
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            write_enable_latch <= 1'b0;
        end
        else if (command.cs && sclk_rise && state == scl_pkg::SCL_HEADER
                 && hdr_count == `SCL_HDR_LAST)
        begin
            if (next_op == `SCL_OP_WREN)
            begin
                write_enable_latch <= 1'b1;
            end
            else if (next_op == `SCL_OP_WRDI)
            begin
                write_enable_latch <= 1'b0;
            end
        end
        else if (command.cs && sclk_rise && state == scl_pkg::SCL_WRITE_IN
                 && in_count == `SCL_BYTE_LAST)
        begin
            write_enable_latch <= 1'b0;
        end
    end

    // Refused-write flag: set beats the clear by readback read
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            write_refused <= 1'b0;
        end
        else if (command.cs && sclk_rise && state == scl_pkg::SCL_WRITE_IN
                 && in_count == `SCL_BYTE_LAST && !addr_writable)
        begin
            write_refused <= 1'b1;
        end
        else if (rd_i && addr_i == `SCL_ADDR_READBACK)
        begin
            write_refused <= 1'b0;
        end
    end

    // Store array
    scl_store_mem u_store (
        .clock_i(clock_i),
        .rd_en_i(mem_rd_en),
        .wr_en_i(mem_wr_en),
        .addr_i(mem_addr),
        .wdata_i(next_in),
        .rdata_o(mem_rdata)
    );

    // Converter input shift: sees every clock rise, store traffic included,
    // which is harmless because only a strobe moves it into an output
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            trim_shift <= 12'h000;
        end
        else if (sclk_rise)
        begin
            trim_shift <= {trim_shift[10:0], command.sdi};
        end
    end

    // Two banks of twelve 8-bit converters, one strobe each
    scl_trim_bank u_bank0 (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .load_i(ld0_rise),
        .frame_i(trim_shift),
        .values_o(trim_bank0_o)
    );

    scl_trim_bank u_bank1 (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .load_i(ld1_rise),
        .frame_i(trim_shift),
        .values_o(trim_bank1_o)
    );

    // Wide converter takes all twelve shifted bits on its own strobe
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            trim_wide_o <= 12'h000;
        end
        else if (ld2_rise)
        begin
            trim_wide_o <= trim_shift;
        end
    end

    // Register read port: data in the cycle after the strobe, zero elsewhere
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i && addr_i == `SCL_ADDR_READBACK)
        begin
            rdata_o <= 8'h00;
            rdata_o[`SCL_BIT_DOUT] <= nvm_data_out_bit;
            rdata_o[`SCL_BIT_WEL] <= write_enable_latch;
            rdata_o[`SCL_BIT_BUSY] <= (state == scl_pkg::SCL_READ_OUT);
            rdata_o[`SCL_BIT_REFUSED] <= write_refused;
        end
        else
        begin
            rdata_o <= 8'h00; // Command register and holes read zero
        end
    end

endmodule

// ---- design/scl_pkg.sv ----
// Types shared by the calibration loader modules
package scl_pkg;

    // Command register layout, bit 0 at the right
    typedef struct packed {
        logic [1:0] spare;
        logic ld2;
        logic ld1;
        logic ld0;
        logic cs;
        logic sdi;
        logic sclk;
    } scl_command_type;

    // Frame shifted into a trim converter: channel then value
    typedef struct packed {
        logic [3:0] channel;
        logic [7:0] value;
    } scl_trim_frame_type;

    // Serial store engine phases
    typedef enum logic [1:0] {
        SCL_HEADER = 2'b00,
        SCL_READ_OUT = 2'b01,
        SCL_WRITE_IN = 2'b10,
        SCL_IGNORE = 2'b11
    } scl_state_type;

endpackage

// ---- design/scl_store_mem.sv ----
// Non-volatile store array, 512 x 8, registered read data
`include "scl_defines.svh"
module scl_store_mem (
    input wire logic clock_i,
    input wire logic rd_en_i,
    input wire logic wr_en_i,
    input wire logic [8:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);

    logic [7:0] cells [0:`SCL_STORE_DEPTH-1];

    // Array contents survive reset on purpose
    always_ff @(posedge clock_i)
    begin
        if (wr_en_i)
        begin
            cells[addr_i] <= wdata_i;
        end
    end

    // Read data hold until the next read
    always_ff @(posedge clock_i)
    begin
        if (rd_en_i)
        begin
            rdata_o <= cells[addr_i];
        end
    end

endmodule

// ---- design/scl_trim_bank.sv ----
// Twelve 8-bit trim converter registers loaded by one strobe
`include "scl_defines.svh"
module scl_trim_bank (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire scl_pkg::scl_trim_frame_type frame_i,
    output logic [8*`SCL_TRIM_CHANNELS-1:0] values_o
);

    genvar ch;

    // One register per converter, selected by the frame channel
    generate
        for (ch = 0; ch < `SCL_TRIM_CHANNELS; ch = ch + 1)
        begin : g_channel
            always_ff @(posedge clock_i)
            begin
                if (reset_i)
                begin
                    values_o[8*ch +: 8] <= 8'h00;
                end
                else if (load_i && frame_i.channel == 4'(ch))
                begin
                    values_o[8*ch +: 8] <= frame_i.value;
                end
            end
        end
    endgenerate

endmodule

// ---- testbench/scl_loader_checker.sv ----
// Port checker for the calibration loader, bound to its top module
`include "scl_defines.svh"
module scl_loader_checker (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic serial_clock_o,
    input wire logic serial_data_o,
    input wire logic nvm_chip_select_o,
    input wire logic [8*`SCL_TRIM_CHANNELS-1:0] trim_bank0_o,
    input wire logic [8*`SCL_TRIM_CHANNELS-1:0] trim_bank1_o,
    input wire logic [11:0] trim_wide_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);

    logic cmd_wr, ld0_wr, ld1_wr, ld2_rise, rb_rd, clk_q, ld2_q;
    logic [2:0] lines, cmd_bits;
    logic [11:0] shadow;

    // Decoded bus strobes
    assign cmd_wr = wr_i && (addr_i == `SCL_ADDR_COMMAND);
    assign rb_rd = rd_i && (addr_i == `SCL_ADDR_READBACK);
    assign ld0_wr = cmd_wr && wdata_i[`SCL_BIT_LD0];
    assign ld1_wr = cmd_wr && wdata_i[`SCL_BIT_LD1];
    assign ld2_rise = cmd_wr && wdata_i[`SCL_BIT_LD2] && !ld2_q;
    assign lines = {nvm_chip_select_o, serial_data_o, serial_clock_o};
    assign cmd_bits = wdata_i[2:0];

    // Shift copy built from the lines; assumes strobe never shares a clock rise
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            clk_q <= 1'b0;
            shadow <= 12'h000;
        end
        else
        begin
            clk_q <= serial_clock_o;
            if (serial_clock_o && !clk_q)
                shadow <= {shadow[10:0], serial_data_o};
        end
    end

    // Last written wide strobe level
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            ld2_q <= 1'b0;
        else if (cmd_wr)
            ld2_q <= wdata_i[`SCL_BIT_LD2];
    end

    sequence s_cmd_write;
        cmd_wr;
    endsequence
    sequence s_idle_read;
        !nvm_chip_select_o ##1 (rb_rd && !nvm_chip_select_o);
    endsequence
    sequence s_wide_load;
        ld2_rise ##2 1'b1;
    endsequence

    a_command_lines: assert property (s_cmd_write |=> lines == $past(cmd_bits))
        else $error("serial lines differ from command write");
    a_lines_hold: assert property (!cmd_wr |=> $stable(lines))
        else $error("serial lines moved without a command write");
    a_rdata_idle: assert property (!rb_rd |=> rdata_o == 8'h00)
        else $error("read data not zero outside readback answer");
    a_dout_deselect: assert property (s_idle_read |=> rdata_o[0] == 1'b0)
        else $error("data out high while store deselected");
    a_bank0_cause: assert property ($changed(trim_bank0_o) |-> $past(ld0_wr, 2))
        else $error("bank 0 changed without its strobe");
    a_bank1_cause: assert property ($changed(trim_bank1_o) |-> $past(ld1_wr, 2))
        else $error("bank 1 changed without its strobe");
    a_wide_cause: assert property ($changed(trim_wide_o) |-> $past(ld2_rise, 2))
        else $error("wide converter changed without its strobe");
    a_wide_value: assert property (s_wide_load |-> trim_wide_o == $past(shadow, 2))
        else $error("wide converter value differs from shifted bits");
endmodule

bind scl_loader scl_loader_checker u_chk (.clock_i(clock_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .serial_clock_o(serial_clock_o), .serial_data_o(serial_data_o),
    .nvm_chip_select_o(nvm_chip_select_o), .trim_bank0_o(trim_bank0_o),
    .trim_bank1_o(trim_bank1_o), .trim_wide_o(trim_wide_o));

// ---- testbench/scl_loader_test.sv ----
// Self-checking bench for the calibration loader
`include "scl_defines.svh"
module scl_loader_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o, got;
    logic serial_clock_o, serial_data_o, nvm_chip_select_o;
    logic [95:0] trim_bank0_o, trim_bank1_o, exp0, exp1;
    logic [11:0] trim_wide_o, exp_wide, wire_frame;
    int mismatches = 0;
    int n_tests = 0;

    always #4 clock_i = ~clock_i;

    scl_loader u_dut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .serial_clock_o(serial_clock_o), .serial_data_o(serial_data_o),
        .nvm_chip_select_o(nvm_chip_select_o), .trim_bank0_o(trim_bank0_o),
        .trim_bank1_o(trim_bank1_o), .trim_wide_o(trim_wide_o));
    scl_trim_shadow u_far (.clock_i(clock_i), .reset_i(reset_i),
        .serial_clock_i(serial_clock_o), .serial_data_i(serial_data_o), .frame_o(wire_frame));

    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [95:0] g, input logic [95:0] e, input string m);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR at %0t: %s", $time, m);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // One bit: data with clock low, clock up, clock down; 20 cycles is 160 ns
    task automatic sh(input logic b, input logic cs);
        wr(`SCL_ADDR_COMMAND, {5'h00, cs, b, 1'b0});
        idle(3);
        wr(`SCL_ADDR_COMMAND, {5'h00, cs, b, 1'b1});
        idle(8);
        wr(`SCL_ADDR_COMMAND, {5'h00, cs, b, 1'b0});
        idle(3);
    endtask

    task automatic shn(input logic [15:0] v, input int n, input logic cs);
        for (int k = n - 1; k >= 0; k--)
            sh(v[k], cs);
    endtask

    task automatic hdr(input logic [6:0] op, input logic [8:0] a);
        wr(`SCL_ADDR_COMMAND, 8'h04);
        shn({op, a}, 16, 1'b1);
    endtask

    // Enable then write one byte; the latch must show before the write
    task automatic store_wr(input logic [8:0] a, input logic [7:0] d);
        hdr(`SCL_OP_WREN, 9'h000);
        wr(`SCL_ADDR_COMMAND, 8'h00);
        rd(`SCL_ADDR_READBACK, got);
        chk(96'(got & 8'h02), 96'h2, "write enable latch");
        hdr(`SCL_OP_WRITE, a);
        shn({8'h00, d}, 8, 1'b1);
        wr(`SCL_ADDR_COMMAND, 8'h00);
    endtask

    task automatic store_rd(input logic [8:0] a, output logic [7:0] d);
        logic [7:0] q;
        hdr(`SCL_OP_READ, a);
        for (int k = 7; k >= 0; k--)
        begin
            rd(`SCL_ADDR_READBACK, q);
            d[k] = q[0];
            chk(96'(q[2]), 96'h1, "read-out phase");
            sh(1'b0, 1'b1);
        end
        wr(`SCL_ADDR_COMMAND, 8'h00);
    endtask

    // Shift a frame with select low, pulse one strobe, compare every converter
    task automatic dac(input int s, input logic [11:0] f);
        shn({4'h0, f}, 12, 1'b0);
        chk(96'(wire_frame), 96'(f), "frame order on wire");
        wr(`SCL_ADDR_COMMAND, 8'h01 << s);
        idle(3);
        wr(`SCL_ADDR_COMMAND, 8'h00);
        chk(trim_bank0_o, exp0, "bank 0 values");
        chk(trim_bank1_o, exp1, "bank 1 values");
        chk(96'(trim_wide_o), 96'(exp_wide), "wide value");
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clock_i);
        mismatches++;
        $display("ERROR at %0t: run limit reached", $time);
        stop_test();
    end

    initial
    begin
        idle(12);
        reset_i <= 1'b0;
        rd(`SCL_ADDR_READBACK, got);
        chk(96'(got), 96'h0, "readback after reset");
        rd(`SCL_ADDR_COMMAND, got);
        chk(96'(got), 96'h0, "command read");
        rd(4'h7, got);
        chk(96'(got), 96'h0, "unmapped read");
        $display("test bus done");
        for (int v = 0; v < 8; v++)
        begin
            wr(`SCL_ADDR_COMMAND, v[7:0]);
            #1 chk(96'({nvm_chip_select_o, serial_data_o, serial_clock_o}), 96'(v), "lines");
        end
        wr(`SCL_ADDR_COMMAND, 8'h00);
        $display("test lines done");
        exp0 = '0;
        exp1 = '0;
        exp_wide = 12'h000;
        exp0[7:0] = 8'h5a;
        dac(3, 12'h05a);
        exp0[95:88] = 8'ha5;
        dac(3, 12'hba5);
        dac(3, 12'hcff);
        exp1[31:24] = 8'h3c;
        dac(4, 12'h33c);
        exp_wide = 12'hc3e;
        dac(5, 12'hc3e);
        $display("test converters done");
        store_wr(`SCL_USER_SETS_BASE, 8'hc5);
        store_rd(`SCL_USER_SETS_BASE, got);
        chk(96'(got), 96'hc5, "stored byte");
        shn({`SCL_OP_WREN, 9'h000}, 16, 1'b0);
        shn({`SCL_OP_WRITE, `SCL_USER_SETS_BASE}, 16, 1'b0);
        shn(16'h003a, 8, 1'b0);
        store_rd(`SCL_USER_SETS_BASE, got);
        chk(96'(got), 96'hc5, "store kept with select low");
        chk(trim_bank0_o, exp0, "bank 0 after store traffic");
        chk(trim_bank1_o, exp1, "bank 1 after store traffic");
        $display("test store done");
        store_wr(`SCL_LOC_BOARD, 8'h11);
        rd(`SCL_ADDR_READBACK, got);
        chk(96'(got & 8'h08), 96'h8, "factory write refused");
        rd(`SCL_ADDR_READBACK, got);
        chk(96'(got & 8'h08), 96'h0, "refused flag cleared");
        store_wr(`SCL_RESERVED_LAST, 8'h22);
        rd(`SCL_ADDR_READBACK, got);
        chk(96'(got & 8'h08), 96'h8, "reserved write refused");
        $display("test protection done");
        // Mid-run reset held several edges so no sampled-value check sees a step
        idle(1);
        reset_i <= 1'b1;
        idle(4);
        reset_i <= 1'b0;
        rd(`SCL_ADDR_READBACK, got);
        chk(96'(got), 96'h0, "readback after mid-run reset");
        exp0 = '0;
        exp1 = '0;
        exp_wide = 12'h000;
        chk(trim_bank0_o, exp0, "bank 0 cleared by reset");
        chk(trim_bank1_o, exp1, "bank 1 cleared by reset");
        chk(96'(trim_wide_o), 96'(exp_wide), "wide cleared by reset");
        store_rd(`SCL_USER_SETS_BASE, got);
        chk(96'(got), 96'hc5, "store kept over reset");
        exp0[31:24] = 8'h77;
        dac(3, 12'h377);
        dac(3, 12'he77);
        $display("test reload done");
        stop_test();
    end
endmodule

// ---- testbench/scl_trim_shadow.sv ----
// Far-side model of the converter shift path on the shared serial lines
module scl_trim_shadow (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    output logic [11:0] frame_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q;

    // Edge finder: the serial clock is slow and software paced
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            clk_q <= 1'b0;
            frame_o <= 12'h000;
        end
        else
        begin
            clk_q <= serial_clock_i;
            if (serial_clock_i && !clk_q)
                frame_o <= {frame_o[10:0], serial_data_i};
        end
    end
endmodule
